// ===== core/der_pkg.sv
// Notes on behaviour
// - Eject flag set: press and completion tones.
// - Eject flag lives in drive non-volatile storage.
// - Page code 01H, length 10, flags byte 2.
// - Write reallocation only when its flag is set.
// - Write cache enabled permits write reallocation anyway.
// - Read reallocation only when its flag is set.
// - Failing block data sent only if flag set; the code also sends it whenever RC is set.
// - Sense reports the failing block's own address.
// - Continuous read: full length, no recovery delays.
// - Early recovery fixed zero; safest recovery used.
// - Post-error: recovered errors raise check condition.
// - Post-error clear: only over-limit errors reported.
// - Stop and post-error: end at first correction.
// - Stop without post-error rejected as illegal request.
// - No stop: full transfer, post recovered at end.
// - Correction disable skips firmware ECC only.
// - Read retries default 4BH, range 0AH to FFH.
// - Retry steps: centre, offtrack 20 percent, ECC, channel.
// - Correction span gives longest correctable burst bits.
// - Write retries default 4BH, range 0AH to FFH.
// - Default flags: retry, correct, report only unrecoverable.
package der_pkg;

    // Page identity and byte positions within the recovery page.
    localparam logic [5:0] PAGE_CODE     = 6'h01;
    localparam logic [7:0] PAGE_LEN      = 8'h0A;
    localparam logic [3:0] OFS_CODE      = 4'h0;
    localparam logic [3:0] OFS_LEN       = 4'h1;
    localparam logic [3:0] OFS_FLAGS     = 4'h2;
    localparam logic [3:0] OFS_RD_RETRY  = 4'h3;
    localparam logic [3:0] OFS_SPAN      = 4'h4;
    localparam logic [3:0] OFS_HEAD_SH   = 4'h5;
    localparam logic [3:0] OFS_STROBE_SH = 4'h6;
    localparam logic [3:0] OFS_WR_RETRY  = 4'h8;
    localparam logic [3:0] OFS_TIME_MSB  = 4'hA;
    localparam logic [3:0] OFS_TIME_LSB  = 4'hB;

    // Bit positions inside the flags byte.
    localparam int BIT_AUTO_WRITE_REALLOC = 7;
    localparam int BIT_AUTO_READ_REALLOC = 6;
    localparam int BIT_TB   = 5;
    localparam int BIT_RC   = 4;
    localparam int BIT_EER  = 3;
    localparam int BIT_PER  = 2;
    localparam int BIT_DTE  = 1;
    localparam int BIT_DCR  = 0;

    // Reset values and count limits.
    localparam logic [7:0] FLAGS_RST   = 8'hC0;
    localparam logic [7:0] RETRY_RST   = 8'h4B;
    localparam logic [7:0] RETRY_MIN   = 8'h0A;
    localparam logic [7:0] SPAN_RST    = 8'h10;
    localparam logic [7:0] OFFTRACK_PCT = 8'h14;

    // Per-block outcome reported by the media channel.
    localparam logic [1:0] ST_CLEAN = 2'h0;
    localparam logic [1:0] ST_RETRY = 2'h1;
    localparam logic [1:0] ST_ECC   = 2'h2;
    localparam logic [1:0] ST_UNREC = 2'h3;

    // Sense keys.
    localparam logic [3:0] SK_NONE      = 4'h0;
    localparam logic [3:0] SK_RECOVERED = 4'h1;
    localparam logic [3:0] SK_MEDIUM    = 4'h3;
    localparam logic [3:0] SK_ILLEGAL   = 4'h5;

    localparam int FIFO_DEPTH = 8;
    localparam int DATA_W     = 32;

    typedef enum logic [1:0] {
        XS_IDLE,
        XS_RUN,
        XS_DRAIN
    } der_xfer_state_t;

endpackage : der_pkg

// ===== core/der_top.sv
`timescale 1ns/1ps
`default_nettype none

// Small synchronous FIFO between the media channel and the initiator data port.
module der_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  room2
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    logic             push;
    logic             pop;

    // Full and empty come straight from the count so back-pressure is exact.
    assign in_ready  = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign room2     = (count_ff <= CW'(DEPTH - 2));
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage array; written only, never reset, to keep it cheap.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers wrap at the depth so non power of two depths also work.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
        end
    end

    // Occupancy count.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_ff <= '0;
        end else if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
        end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
        end
    end

endmodule : der_fifo

// Error recovery policy: holds the recovery page and applies it to transfers.
module der_top (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        pg_wr,
    input  wire logic                        pg_rd,
    input  wire logic [3:0]                  pg_addr,
    input  wire logic [7:0]                  pg_wdata,
    output logic      [7:0]                  pg_rdata,
    input  wire logic                        pg_commit,
    output logic                             sel_done,
    output logic                             sel_reject,
    input  wire logic                        ej_wr,
    input  wire logic                        ej_wdata,
    output logic                             ej_flag,
    input  wire logic                        nv_ej_flag,
    output logic                             nv_wr,
    output logic                             nv_wdata,
    input  wire logic                        eject_btn,
    input  wire logic                        eject_cmpl,
    output logic                             tone_press,
    output logic                             tone_done,
    input  wire logic                        wcache_en,
    input  wire logic                        cmd_start,
    input  wire logic                        cmd_write,
    input  wire logic [15:0]                 cmd_len,
    output logic                             busy,
    output logic                             cmd_done,
    output logic                             check_cond,
    output logic      [3:0]                  sense_key,
    output logic      [31:0]                 sense_lba,
    output logic                             realloc_en,
    output logic                             ecc_en,
    output logic      [7:0]                  retry_limit,
    output logic      [7:0]                  corr_span,
    output logic      [7:0]                  offtrack_pct,
    input  wire logic                        med_valid,
    output logic                             med_ready,
    input  wire logic [der_pkg::DATA_W-1:0]  med_data,
    input  wire logic [31:0]                 med_lba,
    input  wire logic [1:0]                  med_status,
    output logic                             host_valid,
    input  wire logic                        host_ready,
    output logic      [der_pkg::DATA_W-1:0]  host_data
);
    import der_pkg::*;

    logic [7:0]      flags_ff;
    logic [7:0]      rd_retry_ff;
    logic [7:0]      span_ff;
    logic [7:0]      wr_retry_ff;
    logic [7:0]      stg_flags_ff;
    logic [7:0]      stg_rd_ff;
    logic [7:0]      stg_span_ff;
    logic [7:0]      stg_wr_ff;
    logic            sel_bad;
    logic            nv_load_ff;
    logic [2:0]      btn_sync_ff;
    logic [2:0]      cmpl_sync_ff;
    der_xfer_state_t state_ff;
    logic [15:0]     remain_ff;
    logic            dir_wr_ff;
    logic            take;
    logic            fwd;
    logic            stop_now;
    logic            last_take;
    logic            fifo_in_ready;
    logic            fifo_room2;
    logic            nxt_med_ready;
    logic            rec_seen_ff;
    logic [31:0]     rec_lba_ff;
    logic            unrec_seen_ff;
    logic [31:0]     unrec_lba_ff;
    logic            dte_stop_ff;
    logic [31:0]     dte_lba_ff;

    // Staged page is only checked as a whole, so a bad combination never lands.
    assign sel_bad = (stg_flags_ff[BIT_DTE] && !stg_flags_ff[BIT_PER])
                   || (stg_rd_ff < RETRY_MIN)
                   || (stg_wr_ff < RETRY_MIN);

    // Staging bytes written by mode select; offset and time fields are dropped.
    // A good commit keeps the staged bytes, so a later partial select builds on them.
    // Only a rejected commit puts the staging bytes back to the live page.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || (pg_commit && sel_bad)) begin
            stg_flags_ff <= sys_rst ? FLAGS_RST : flags_ff;
            stg_rd_ff    <= sys_rst ? RETRY_RST : rd_retry_ff;
            stg_span_ff  <= sys_rst ? SPAN_RST : span_ff;
            stg_wr_ff    <= sys_rst ? RETRY_RST : wr_retry_ff;
        end else if (pg_wr && !pg_commit) begin
            unique case (pg_addr)
                OFS_FLAGS:    stg_flags_ff <= pg_wdata;
                OFS_RD_RETRY: stg_rd_ff    <= pg_wdata;
                OFS_SPAN:     stg_span_ff  <= pg_wdata;
                OFS_WR_RETRY: stg_wr_ff    <= pg_wdata;
                default:      stg_flags_ff <= stg_flags_ff;  // Unsupported fields stay zero.
            endcase
        end
    end

    // Live page: defaults at reset, replaced only by a valid commit.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flags_ff    <= FLAGS_RST;
            rd_retry_ff <= RETRY_RST;
            span_ff     <= SPAN_RST;
            wr_retry_ff <= RETRY_RST;
        end else if (pg_commit && !sel_bad) begin
            flags_ff    <= stg_flags_ff & ~(8'h01 << BIT_EER);
            rd_retry_ff <= stg_rd_ff;
            span_ff     <= stg_span_ff;
            wr_retry_ff <= stg_wr_ff;
        end
    end

    // Commit answer pulses; a rejected commit means illegal request upstream.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sel_done   <= 1'b0;
            sel_reject <= 1'b0;
        end else begin
            sel_done   <= pg_commit;
            sel_reject <= pg_commit && sel_bad;
        end
    end

    // Page readback, one cycle after the read strobe.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pg_rdata <= 8'h00;
        end else if (pg_rd) begin
            unique case (pg_addr)
                OFS_CODE:     pg_rdata <= {2'b00, PAGE_CODE};
                OFS_LEN:      pg_rdata <= PAGE_LEN;
                OFS_FLAGS:    pg_rdata <= flags_ff;
                OFS_RD_RETRY: pg_rdata <= rd_retry_ff;
                OFS_SPAN:     pg_rdata <= span_ff;
                OFS_WR_RETRY: pg_rdata <= wr_retry_ff;
                default:      pg_rdata <= 8'h00;
            endcase
        end
    end

    // The eject flag is owned by drive storage, so it is reloaded after every reset.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ej_flag    <= 1'b1;
            nv_load_ff <= 1'b1;
            nv_wr      <= 1'b0;
            nv_wdata   <= 1'b1;
        end else begin
            nv_load_ff <= 1'b0;
            nv_wr      <= ej_wr;
            if (ej_wr) begin
                ej_flag  <= ej_wdata;
                nv_wdata <= ej_wdata;
            end else if (nv_load_ff) begin
                ej_flag  <= nv_ej_flag;
            end
        end
    end

    // Button and mechanism pins are asynchronous; bit 2 only feeds the edge detect.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            btn_sync_ff  <= 3'b000;
            cmpl_sync_ff <= 3'b000;
        end else begin
            btn_sync_ff  <= {btn_sync_ff[1:0], eject_btn};
            cmpl_sync_ff <= {cmpl_sync_ff[1:0], eject_cmpl};
        end
    end

    // Two distinct tone triggers, both silenced when the flag is clear.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tone_press <= 1'b0;
            tone_done  <= 1'b0;
        end else begin
            tone_press <= ej_flag && btn_sync_ff[1] && !btn_sync_ff[2];
            tone_done  <= ej_flag && cmpl_sync_ff[1] && !cmpl_sync_ff[2];
        end
    end

    // Recovery controls handed to the media channel, fixed for each command.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            realloc_en   <= 1'b0;
            ecc_en       <= 1'b1;
            retry_limit  <= RETRY_RST;
            corr_span    <= SPAN_RST;
            offtrack_pct <= OFFTRACK_PCT;
        end else if (cmd_start && state_ff == XS_IDLE) begin
            if (cmd_write) begin
                realloc_en  <= flags_ff[BIT_AUTO_WRITE_REALLOC] || wcache_en;
                retry_limit <= wr_retry_ff;
            end else begin
                // Reallocation adds delay, so continuous read suppresses it.
                realloc_en  <= flags_ff[BIT_AUTO_READ_REALLOC] && !flags_ff[BIT_RC];
                retry_limit <= flags_ff[BIT_RC] ? 8'h00 : rd_retry_ff;
            end
            ecc_en       <= !flags_ff[BIT_DCR];
            corr_span    <= span_ff;
            offtrack_pct <= OFFTRACK_PCT;
        end
    end

    // Per-block decisions for the block taken this cycle.
    assign take      = (state_ff == XS_RUN) && med_valid && med_ready;
    assign fwd       = (med_status != ST_UNREC) || flags_ff[BIT_TB]
                     || flags_ff[BIT_RC];
    assign stop_now  = !flags_ff[BIT_RC]
                     && ((med_status == ST_UNREC)
                         || (flags_ff[BIT_PER] && flags_ff[BIT_DTE]
                             && med_status == ST_ECC));
    assign last_take = take && (stop_now || remain_ff == 16'h0001);

    // Ready is registered; the FIFO keeps two spare slots so one late push fits.
    assign nxt_med_ready = (state_ff == XS_RUN) && !last_take && fifo_room2
                         && !(state_ff == XS_RUN && remain_ff == 16'h0000);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            med_ready <= 1'b0;
        end else begin
            med_ready <= nxt_med_ready;
        end
    end

    // Transfer sequencing: run until length, stop or fault, then drain the FIFO.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff  <= XS_IDLE;
            remain_ff <= 16'h0000;
            dir_wr_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                XS_IDLE: begin
                    if (cmd_start) begin
                        remain_ff <= cmd_len;
                        dir_wr_ff <= cmd_write;
                        state_ff  <= (cmd_len == 16'h0000) ? XS_DRAIN : XS_RUN;
                    end
                end
                XS_RUN: begin
                    if (take) begin
                        remain_ff <= remain_ff - 16'h0001;
                    end
                    if (last_take || remain_ff == 16'h0000) begin
                        state_ff <= XS_DRAIN;
                    end
                end
                XS_DRAIN: begin
                    if (!host_valid) begin
                        state_ff <= XS_IDLE;
                    end
                end
            endcase
        end
    end

    // Error bookkeeping; addresses are those of the erring block itself.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || (cmd_start && state_ff == XS_IDLE)) begin
            rec_seen_ff   <= 1'b0;
            rec_lba_ff    <= 32'h0000_0000;
            unrec_seen_ff <= 1'b0;
            unrec_lba_ff  <= 32'h0000_0000;
            dte_stop_ff   <= 1'b0;
            dte_lba_ff    <= 32'h0000_0000;
        end else if (take) begin
            if ((med_status == ST_RETRY || med_status == ST_ECC) && flags_ff[BIT_PER]
                && !flags_ff[BIT_RC]) begin
                rec_seen_ff <= 1'b1;
                rec_lba_ff  <= med_lba;        // Last recovered wins.
            end
            if (med_status == ST_UNREC && !unrec_seen_ff) begin
                unrec_seen_ff <= 1'b1;
                unrec_lba_ff  <= med_lba;      // First unrecoverable wins.
            end
            if (stop_now && med_status == ST_ECC) begin
                dte_stop_ff <= 1'b1;
                dte_lba_ff  <= med_lba;
            end
        end
    end

    // Completion status, reported once the data has left the FIFO.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd_done   <= 1'b0;
            check_cond <= 1'b0;
            sense_key  <= SK_NONE;
            sense_lba  <= 32'h0000_0000;
        end else begin
            cmd_done <= 1'b0;
            if (state_ff == XS_DRAIN && !host_valid) begin
                cmd_done <= 1'b1;
                if (unrec_seen_ff) begin
                    check_cond <= 1'b1;
                    sense_key  <= SK_MEDIUM;
                    sense_lba  <= unrec_lba_ff;
                end else if (dte_stop_ff) begin
                    check_cond <= 1'b1;
                    sense_key  <= SK_RECOVERED;
                    sense_lba  <= dte_lba_ff;
                end else if (rec_seen_ff) begin
                    check_cond <= 1'b1;
                    sense_key  <= SK_RECOVERED;
                    sense_lba  <= rec_lba_ff;
                end else begin
                    check_cond <= 1'b0;
                    sense_key  <= SK_NONE;
                    sense_lba  <= 32'h0000_0000;
                end
            end
        end
    end

    // Busy covers the whole command including the drain.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_ff != XS_IDLE) || (cmd_start && state_ff == XS_IDLE);
        end
    end

    // Withheld failing blocks are simply not pushed.
    der_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (take && fwd),
        .in_ready  (fifo_in_ready),
        .in_data   (med_data),
        .out_valid (host_valid),
        .out_ready (host_ready),
        .out_data  (host_data),
        .room2     (fifo_room2)
    );

    // The spare-slot margin means a push is never refused; unused otherwise.
    logic unused_ok;
    assign unused_ok = fifo_in_ready & dir_wr_ff;

endmodule : der_top

`default_nettype wire

// ===== bench/der_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host initiator data sink: it takes words with random stalls, as a slow host would.
module der_host_model (
    input  wire logic sys_clk,
    input  wire logic stall,
    output logic      host_ready
);
    integer seed = 94550;

    // Ready changes just after each edge. A forced stall lets the bench fill the buffer.
    initial host_ready = 1'h0;
    always @(posedge sys_clk) begin
        host_ready <= #1 !stall && (($random(seed) & 3) != 0);
    end
endmodule : der_host_model
`default_nettype wire

// ===== bench/der_checker.sv
`timescale 1ns/1ps
`default_nettype none

// Timing relations between the recovery block's requests and its answers.
module der_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic pg_commit,
    input wire logic sel_done,
    input wire logic sel_reject,
    input wire logic ej_wr,
    input wire logic ej_wdata,
    input wire logic ej_flag,
    input wire logic nv_wr,
    input wire logic nv_wdata,
    input wire logic tone_press,
    input wire logic cmd_start,
    input wire logic busy,
    input wire logic cmd_done,
    input wire logic med_ready,
    input wire logic host_valid,
    input wire logic ecc_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_sel; pg_commit |=> sel_done; endproperty
    a_sel: assert property (p_sel) else $error("commit not answered");
    property p_rej; sel_reject |-> sel_done && $past(pg_commit); endproperty
    a_rej: assert property (p_rej) else $error("stray reject");
    property p_nv; ej_wr |=> nv_wr && (nv_wdata == $past(ej_wdata)); endproperty
    a_nv: assert property (p_nv) else $error("eject flag not stored");
    property p_tone; tone_press |-> $past(ej_flag); endproperty
    a_tone: assert property (p_tone) else $error("tone while silent");
    property p_start; cmd_start && !busy |=> busy ##1 med_ready; endproperty
    a_start: assert property (p_start) else $error("transfer did not start");
    property p_done; cmd_done |-> !host_valid; endproperty
    a_done: assert property (p_done) else $error("done with data left");
    property p_rst; $fell(sys_rst) |-> ej_flag && ecc_en && !busy && !med_ready; endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_idle; med_ready |-> busy; endproperty
    a_idle: assert property (p_idle) else $error("media taken while idle");
endmodule : der_checker
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end

module tb;
    import der_pkg::*;
    localparam logic [95:0] PAGE_RST = 96'h010A_C04B_1000_0000_4B00_0000;
    logic sys_clk = 1'h0, sys_rst = 1'h1, pg_wr = 1'h0, pg_rd = 1'h0, pg_commit = 1'h0;
    logic ej_wr = 1'h0, ej_wdata = 1'h0, nv_ej_flag = 1'h1, eject_btn = 1'h0;
    logic eject_cmpl = 1'h0, wcache_en = 1'h0, cmd_start = 1'h0, cmd_write = 1'h0;
    logic med_valid = 1'h0, stall = 1'h0, host_ready;
    logic [3:0] pg_addr = 4'h0, sense_key;
    logic [7:0] pg_wdata = 8'h00, pg_rdata, retry_limit, corr_span, offtrack_pct;
    logic [15:0] cmd_len = 16'h0000;
    logic [31:0] med_data = 32'h0000_0000, med_lba = 32'h0000_0000, sense_lba, host_data;
    logic [1:0] med_status = 2'h0;
    logic sel_done, sel_reject, ej_flag, nv_wr, nv_wdata, tone_press, tone_done, busy;
    logic cmd_done, check_cond, realloc_en, ecc_en, med_ready, host_valid;
    int seed = 94550, compares = 0, mismatches = 0, tones = 0, dones = 0;
    logic [31:0] exp_q[$], exp_w;
    logic [36:0] sns_q[$], exp_s;

    der_top DUT (.*);
    der_host_model u_host (.sys_clk(sys_clk), .stall(stall), .host_ready(host_ready));

    always #10 sys_clk = ~sys_clk;

    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic pg(input logic [3:0] a, input logic [7:0] d);
        pg_addr = a; pg_wdata = d; pg_wr = 1'h1; tick(); pg_wr = 1'h0; tick();
    endtask : pg

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        pg_addr = a; pg_rd = 1'h1; tick(); pg_rd = 1'h0; tick();
        `CHK("page byte", e, pg_rdata)
    endtask : rd

    // The answer lands on the commit edge, so it is looked at just after it.
    task automatic commit(input logic rej);
        pg_commit = 1'h1; tick(); pg_commit = 1'h0;
        `CHK("sel_reject", rej, sel_reject)
        tick();
    endtask : commit

    task automatic start(input logic wr, input logic [15:0] len);
        cmd_write = wr; cmd_len = len; cmd_start = 1'h1; tick(); cmd_start = 1'h0;
    endtask : start

    // Valid is held between blocks, so consecutive blocks go back to back.
    task automatic blk(input logic [31:0] l, input logic [1:0] s, input logic push);
        int n = 0;
        med_lba = l; med_status = s; med_data = $random(seed); med_valid = 1'h1;
        if (push) exp_q.push_back(med_data);
        do begin @(posedge sys_clk); n++; end while (!med_ready && n < 200);
        #1;
        if (n >= 200) begin mismatches++; end_of_test(); end
    endtask : blk

    task automatic fin(input logic c, input logic [3:0] k, input logic [31:0] l);
        int n = 0;
        med_valid = 1'h0; sns_q.push_back({c, k, l});
        do begin @(posedge sys_clk); n++; end while (!cmd_done && n < 400);
        tick(2);
        if (n >= 400) begin mismatches++; end_of_test(); end
    endtask : fin

    // Results are taken off the queues in the order the driver noted them.
    // Each note is popped once into exp_w or exp_s, since the compare macro reads it twice.
    always @(posedge sys_clk) begin
        if (host_valid && host_ready) begin
            exp_w = exp_q.pop_front();
            `CHK("host_data", exp_w, host_data)
        end
        if (cmd_done) begin
            exp_s = sns_q.pop_front();
            `CHK("sense", exp_s, {check_cond, sense_key, sense_lba})
        end
        if (tone_press) tones++;
        if (tone_done) dones++;
    end

    initial begin
        tick(4); sys_rst = 1'h0; tick();
        for (int i = 0; i < 12; i++) rd(i[3:0], PAGE_RST[95-8*i -: 8]);
        `CHK("retry_limit", RETRY_RST, retry_limit)
        ej_wdata = 1'h1; ej_wr = 1'h1; tick(); ej_wr = 1'h0;
        eject_btn = 1'h1; eject_cmpl = 1'h1; tick(8);
        `CHK("tones", 1, tones)
        `CHK("done tones", 1, dones)
        eject_btn = 1'h0; eject_cmpl = 1'h0;
        ej_wdata = 1'h0; ej_wr = 1'h1; tick(); ej_wr = 1'h0;
        tick(); eject_btn = 1'h1; eject_cmpl = 1'h1; tick(8);
        eject_btn = 1'h0; eject_cmpl = 1'h0;
        `CHK("silent", 1, tones)
        `CHK("silent done", 1, dones)
        pg(2, 8'hC8); pg(5, 8'h00); commit(0); rd(2, 8'hC0);
        pg(2, 8'h02); commit(1); rd(2, 8'hC0);
        pg(3, 8'h09); commit(1); rd(3, 8'h4B);
        pg(3, 8'h0A); pg(8, 8'hFF); commit(0); rd(3, 8'h0A); rd(8, 8'hFF);
        stall = 1'h1; start(0, 16'h0008);
        fork begin tick(40); stall = 1'h0; end join_none
        `CHK("realloc_en", 1'h1, realloc_en)
        `CHK("ecc_en", 1'h1, ecc_en)
        `CHK("read retries", 8'h0A, retry_limit)
        `CHK("corr_span", SPAN_RST, corr_span)
        `CHK("offtrack_pct", OFFTRACK_PCT, offtrack_pct)
        for (int i = 0; i < 7; i++) blk(100 + i, ST_CLEAN, 1);
        blk(107, ST_UNREC, 0); fin(1, SK_MEDIUM, 107);
        pg(2, 8'hC6); commit(0); start(0, 16'h0004);
        blk(200, ST_RETRY, 1); blk(201, ST_ECC, 1); fin(1, SK_RECOVERED, 201);
        pg(2, 8'h04); commit(0); start(0, 16'h0003);
        blk(400, ST_RETRY, 1); blk(401, ST_ECC, 1); blk(402, ST_CLEAN, 1);
        fin(1, SK_RECOVERED, 401);
        pg(2, 8'h21); commit(0); start(1, 16'h0001);
        `CHK("realloc_en", 1'h0, realloc_en)
        `CHK("ecc_en", 1'h0, ecc_en)
        blk(300, ST_UNREC, 1); fin(1, SK_MEDIUM, 300);
        wcache_en = 1'h1; start(1, 16'h0001);
        `CHK("realloc_en", 1'h1, realloc_en)
        blk(301, ST_UNREC, 1); fin(1, SK_MEDIUM, 301); wcache_en = 1'h0;
        pg(2, 8'h10); commit(0); start(0, 16'h0002);
        `CHK("rc retries", 8'h00, retry_limit)
        blk(500, ST_UNREC, 1); blk(501, ST_CLEAN, 1); fin(1, SK_MEDIUM, 500);
        pg(2, 8'h00); commit(0); start(0, 16'h0002);
        `CHK("realloc_en", 1'h0, realloc_en)
        blk(600, ST_RETRY, 1); blk(601, ST_ECC, 1); fin(0, SK_NONE, 0);
        end_of_test();
    end
endmodule : tb

bind der_top der_checker u_chk (.*);
`default_nettype wire
